// [bench/maint_sva.sv]
/* checker: port relations of the maintenance test block
   assumes a bind to its top module, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module maint_sva
  import maint_pkg::*;
(
  input wire logic       hclk,        // clock
  input wire logic       hresetn,     // reset, low
  input wire cpu_evt_s   cpu,         // cpu events
  input wire logic [3:0] clk_en,      // clocks
  input wire logic [2:0] ctl_mode,    // source
  input wire logic       logout_req,  // logout
  input wire logic       mc_irpt_req, // check irpt
  input wire manual_op_s manual_op,   // pulses
  input wire logic       adr_compare  // compare
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_HALT: assert property (cpu.hard_err |=> clk_en == 4'h0)
    else $error("clocks run after hard error");
  AST_CLK_RUN: assert property (clk_en != 4'h0 |->
    clk_en == $past(cpu.clk_req)) else $error("clock report wrong");
  AST_ONE_SRC: assert property ($onehot(ctl_mode))
    else $error("control source not one-hot");
  AST_LOGOUT: assert property (cpu.logout_err |=> logout_req)
    else $error("logout trigger missing");
  AST_MC_DONE: assert property (cpu.mc_taken |=> !mc_irpt_req)
    else $error("check request after taken");
  AST_MC_SRC: assert property ($rose(mc_irpt_req) |-> $past(cpu.psw13))
    else $error("check request while masked");
  AST_STEP: assert property (manual_op.instr_step |-> !$past(cpu.psw14))
    else $error("step with wait bit on");
  AST_ADR: assert property (adr_compare |->
    !$past(cpu.manual_state) && !$past(cpu.psw14))
    else $error("compare in manual or wait");
endmodule
`default_nettype wire

// [bench/panel_model.sv]
/* operator panel model: data switches, rate and stop keys
   assumes calls right after a rising hclk edge */
`timescale 1ns/1ps
`default_nettype none
module panel_model
  import maint_pkg::*;
(
  input  wire logic  hclk,  // bus clock
  output var panel_s panel  // panel pins
);
  initial panel = '0;
  // levels held past the design's pin filter
  task automatic set(input panel_s p);
    panel <= p;
    repeat (6) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
/* bench: bus tasks, cpu event pulses, panel model
   assumes the one-cycle bus answer of the block */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import maint_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, manual_data, r;
  logic [1:0]  htrans;
  logic [3:0]  clk_en, key_reg;
  logic [2:0]  ctl_mode;
  logic [5:0]  test_op;
  logic        cycle_advance, storage_fetch, storage_inhibit;
  logic        logout_req, mc_irpt_req, adr_compare;
  cpu_evt_s    cpu;
  panel_s      panel;
  manual_op_s  manual_op, acc;
  int          errors, n_tests;
  localparam cpu_evt_s WORD = '{load_word: 1'b1, default: '0};
  localparam cpu_evt_s GOOD = '{cmp_good: 1'b1, default: '0};
  localparam cpu_evt_s TEND = '{test_end: 1'b1, default: '0};
  localparam cpu_evt_s HERR = '{hard_err: 1'b1, default: '0};
  localparam cpu_evt_s ERRS = '{err_reg_set: 1'b1, default: '0};
  localparam cpu_evt_s LOGT = '{logout_taken: 1'b1, default: '0};
  localparam cpu_evt_s LOGE = '{logout_err: 1'b1, default: '0};
  localparam cpu_evt_s MCT  = '{mc_taken: 1'b1, default: '0};
  maintenance_test_control i_dut (.hsize(3'h2), .hready(hreadyout), .*);
  panel_model i_panel (.hclk(hclk), .panel(panel));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic pulse(input cpu_evt_s m);
    cpu <= cpu | m;
    cyc(1);
    cpu <= cpu & ~m;
    cyc(1);
  endtask
  task automatic waitfor(ref logic s);
    for (int i = 0; i < 50 && s !== 1'b1; i++) @(posedge hclk);
  endtask
  task automatic t_load(input logic [31:0] c, input logic [6:0] e);
    bus(CTRL_OFS, 1'b1, c);
    repeat (3) pulse(WORD);
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[16:10], e)
    pulse(WORD);
  endtask
  task automatic t_test;
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r, 32'h0080_0000)
    bus(8'h20, 1'b0, 32'h0);
    `CHK(r, 32'h0)
    t_load(32'h0000_01a9, 7'h44);
    cyc(1);
    `CHK(cycle_advance, 1'b1)
    repeat (16) begin
      pulse(GOOD);
      pulse(GOOD);
      pulse(TEND);
    end
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[9:0], 10'h2a9)
    `CHK(test_op, 6'h2a)
    t_load(32'h0000_0005, 7'h47);
    pulse(GOOD);
    pulse(TEND);
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[3:0], 4'h6)
    bus(CTRL_OFS, 1'b1, 32'h5);
    pulse('{load_word: 1'b1, load_perr: 1'b1, default: '0});
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[17], 1'b1)
    $display("test run done");
  endtask
  task automatic t_stop;
    cpu.clk_req <= 4'ha;
    cyc(3);
    `CHK(clk_en, 4'ha)
    pulse(HERR);
    `CHK(clk_en, 4'h0)
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[25], 1'b1)
    bus(CTRL_OFS, 1'b1, 32'h2);
    cyc(2);
    `CHK(clk_en, 4'ha)
    pulse(ERRS);
    bus(IND_HI_OFS, 1'b0, 32'h0);
    `CHK(r[3:0], 4'h9)
    `CHK(logout_req, 1'b0)
    cpu.psw13 <= 1'b1;
    waitfor(logout_req);
    `CHK(logout_req, 1'b1)
    pulse(LOGT);
    waitfor(mc_irpt_req);
    `CHK(mc_irpt_req, 1'b1)
    pulse(MCT);
    `CHK(mc_irpt_req, 1'b0)
    bus(IND_HI_OFS, 1'b0, 32'h0);
    `CHK(r[3:0], 4'h3)
    pulse(LOGE);
    `CHK(logout_req, 1'b1)
    bus(CTRL_OFS, 1'b1, 32'h700);
    cpu.diagnose <= 1'b1;
    cyc(2);
    `CHK(storage_fetch, 1'b1)
    `CHK(storage_inhibit, 1'b0)
    `CHK(ctl_mode, 3'h2)
    cpu.diagnose <= 1'b0;
    cyc(2);
    `CHK(storage_fetch, 1'b0)
    `CHK(storage_inhibit, 1'b1)
    $display("stop and check done");
  endtask
  task automatic t_man;
    manual_op_s ex [16] = '{10'h200, 10'h100, 10'h080, 10'h040, '0, '0, '0,
      '0, 10'h020, 10'h010, 10'h004, '0, 10'h002, 10'h001, 10'h028, 10'h018};
    i_panel.set('{data_sw: 32'h1234_5679, default: '0});
    for (int i = 0; i < 16; i++) begin
      acc = '0;
      bus(MAN_OFS, 1'b1, 32'(i) | 32'h10);
      repeat (3) begin
        @(posedge hclk);
        acc = acc | manual_op;
      end
      `CHK(acc, ex[i])
    end
    `CHK(key_reg, 4'h9)
    `CHK(manual_data, 32'h1234_5679)
    i_panel.set('{stop_sync: 1'b1, default: '0});
    bus(MAN_OFS, 1'b1, 32'h4);
    cyc(2);
    `CHK(adr_compare, 1'b1)
    cpu.manual_state <= 1'b1;
    cyc(2);
    `CHK(adr_compare, 1'b0)
    i_panel.set('{rate_single: 1'b1, default: '0});
    i_panel.set('0);
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[28], 1'b1)
    i_panel.set('{start_pb: 1'b1, default: '0});
    bus(IND_OFS, 1'b0, 32'h0);
    `CHK(r[28], 1'b0)
    $display("manual done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, cpu} = '0;
    errors = 0;
    n_tests = 0;
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    t_test;
    t_stop;
    t_man;
    tally_and_finish;
  end
  initial begin
    cyc(5000);
    errors++;
    tally_and_finish;
  end
endmodule
bind maintenance_test_control maint_sva i_sva (.*);
`default_nettype wire

// [design/maint_pkg.sv]
/*
  Shared constants and types for the maintenance test control block:
  register offsets, field positions, counts, manual codes, carriers.
  Assumes a 32-bit AHB-Lite slave with one word per register.
*/
package maint_pkg;

  // register byte offsets, decoded on haddr[7:0]
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MAN_OFS    = 8'h04;
  localparam logic [7:0] IND_OFS    = 8'h08;
  localparam logic [7:0] IND_HI_OFS = 8'h0c;
  localparam logic [7:0] KEY_OFS    = 8'h10;

  // control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_CLEAR  = 1;
  localparam int CTRL_OP_LSB = 2;
  localparam int CTRL_SUPV   = 8;
  localparam int CTRL_SCAN   = 9;
  localparam int CTRL_SENA   = 10;
  // manual register fields
  localparam int MAN_CODE_LSB = 0;
  localparam int MAN_GO       = 4;

  // reset values and counts
  localparam logic [4:0] REPEAT_INIT = 5'h10;
  localparam logic [2:0] SEQ_LOAD    = 3'h7;
  localparam logic [3:0] STEP_FIRST  = 4'h1;
  localparam logic [5:0] OP_RESET    = 6'h00;
  localparam logic [3:0] CODE_RESET  = 4'h0;

  // manual operation codes on general flags 4..7
  localparam logic [3:0] MC_HALT      = 4'h0;
  localparam logic [3:0] MC_STEP      = 4'h1;
  localparam logic [3:0] MC_SET_IAR   = 4'h2;
  localparam logic [3:0] MC_REPEAT    = 4'h3;
  localparam logic [3:0] MC_ADR_CMP   = 4'h4;
  localparam logic [3:0] MC_MS_DISP   = 4'h8;
  localparam logic [3:0] MC_MS_STORE  = 4'h9;
  localparam logic [3:0] MC_KEY_DISP  = 4'ha;
  localparam logic [3:0] MC_KEY_STORE = 4'hb;
  localparam logic [3:0] MC_LS_DISP   = 4'hc;
  localparam logic [3:0] MC_LS_STORE  = 4'hd;
  localparam logic [3:0] MC_BS_DISP   = 4'he;
  localparam logic [3:0] MC_BS_STORE  = 4'hf;

  typedef enum logic [1:0] {T_IDLE, T_LOAD, T_EXEC, T_DONE} test_state_e;
  typedef enum logic [1:0] {SRC_COUNTER, SRC_STORAGE, SRC_STORE} ctl_src_e;

  // indicator set, field order gives bit position (pass is bit 0)
  typedef struct packed {
    logic       machine_check_pending;
    logic       chk_gated;
    logic       chk_allowed;
    logic [3:0] clk_run;      // main storage, control store, channel, cpu
    logic       single_cycle;
    logic       block_ind;
    logic       logout_tgr;
    logic       halt;
    logic       alt_prefix;
    logic [2:0] mode;         // control store, storage, counter
    logic       store_enable;
    logic       scan;
    logic       supv;
    logic       parity_err;
    logic [3:0] load_step;
    logic [2:0] seq;
    logic [5:0] op;
    logic       rep_zero;
    logic       toggle;
    logic       fail;
    logic       pass;
  } ind_s;

  // processor-side events and levels, same clock
  typedef struct packed {
    logic       load_word;
    logic       load_perr;
    logic       cmp_good;
    logic       cmp_bad;
    logic       test_end;
    logic       diagnose;
    logic       hard_err;
    logic       logout_err;
    logic       err_reg_set;
    logic       logout_taken;
    logic       mc_taken;
    logic       psw13;
    logic       psw14;
    logic       manual_state;
    logic [3:0] clk_req;
  } cpu_evt_s;

  // operator panel pins, asynchronous
  typedef struct packed {
    logic        rate_single;
    logic        start_pb;
    logic        stop_sync;
    logic [31:0] data_sw;
  } panel_s;

  localparam int PANEL_W = $bits(panel_s);

  typedef struct packed {
    logic halt_loop;
    logic instr_step;
    logic set_iar;
    logic repeat_instr;
    logic stor_display;
    logic stor_store;
    logic bump;
    logic key_display;
    logic local_display;
    logic local_store;
  } manual_op_s;

endpackage

// [design/maintenance_test_control.sv]
/*
  Maintenance test control: fault-locating test load and execution,
  control source selection, clock halt, check pending and manual
  operation decode, with an AHB-Lite register slave.
  Assumes processor events on hclk; panel pins asynchronous.
*/
// Added by the designer: the address map and the AHB-Lite slave port.
// Functional notes
// - pass bit 0, fail bit 1
// - toggle flips per good comparison
// - repeat counter zero after 16 runs
// - six-bit test operation register, driven out undecoded on test_op
// - sequence counter steers load, advances clock
// - four load-step flags drive load
// - parity error flags failed test load
// - counter decrements only under supervisory flag
// - progressive scan fetches from main storage during diagnose
// - store enable cancels supervisory inhibit during diagnose
// - exactly one control source at once
// - error_clock_halt halts all four clocks
// - logout trigger set on logout error
// - single cycle holds until start pressed
// - report each clock running separately
// - check interrupt allowed when taken possible
// - masked error sets pending, unmask raises
// - manual codes 0 to 3 decoded
// - address compare needs stop, not manual
// - codes 8,9,E,F storage display/store
// - key display and key store codes
// - codes C,D local storage via L
`timescale 1ns/1ps
`default_nettype none

module maintenance_test_control
  import maint_pkg::*;
(
  input  wire logic        hclk,          // 250 MHz bus clock
  input  wire logic        hresetn,       // async reset, low
  input  wire logic        hsel,          // slave select
  input  wire logic [31:0] haddr,         // byte address
  input  wire logic [1:0]  htrans,        // transfer type
  input  wire logic        hwrite,        // write when high
  input  wire logic [2:0]  hsize,         // word only
  input  wire logic        hready,        // bus ready in
  input  wire logic [31:0] hwdata,        // write data
  output logic      [31:0] hrdata,        // read data
  output logic             hreadyout,     // always ready
  output logic             hresp,         // always okay
  input  wire cpu_evt_s    cpu,           // processor events
  input  wire panel_s      panel,         // panel pins
  output logic      [3:0]  clk_en,        // clock enables
  output logic             cycle_advance, // test clock step
  output logic             storage_fetch, // scan fetch request
  output logic             storage_inhibit, // supervisory inhibit
  output logic             logout_req,    // logout trigger
  output logic             mc_irpt_req,   // machine check request
  output logic      [2:0]  ctl_mode,      // control source
  output logic      [5:0]  test_op,       // test operation
  output manual_op_s       manual_op,     // manual pulses
  output logic             adr_compare,   // address compare level
  output logic      [31:0] manual_data,   // captured switches
  output logic      [3:0]  key_reg        // storage key
);

  panel_s      pnl;
  test_state_e state_q;
  ctl_src_e    src_q;
  ind_s        ind;
  manual_op_s  mop_d;
  manual_op_s  mop_q;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        wr_ctrl;
  logic        wr_man;
  logic        start_w;
  logic        clear_w;
  logic        go_w;
  logic [5:0]  op_q;
  logic        supv_q;
  logic        scan_q;
  logic        sena_q;
  logic [3:0]  code_q;
  logic [3:0]  code_w;
  logic [3:0]  step_q;
  logic [2:0]  seq_q;
  logic [4:0]  rep_q;
  logic        toggle_q;
  logic        bad_q;
  logic        pass_q;
  logic        fail_q;
  logic        perr_q;
  logic        halt_q;
  logic [3:0]  clk_q;
  logic        adv_q;
  logic        fetch_q;
  logic        inhibit_q;
  logic        logout_q;
  logic        pend_q;
  logic        logged_q;
  logic        mcreq_q;
  logic        allow_q;
  logic        single_q;
  logic        start_prev_q;
  logic        adrcmp_q;
  logic [31:0] mdata_q;
  logic [3:0]  key_q;

  pin_sync #(.W(PANEL_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (panel),
    .pin_out (pnl)
  );

  // bus slave: zero wait, read data latched in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  always_comb begin
    rd_mux = 32'h0;
    if (haddr[7:0] == CTRL_OFS) begin
      rd_mux[CTRL_OP_LSB +: 6] = op_q;
      rd_mux[CTRL_SUPV]        = supv_q;
      rd_mux[CTRL_SCAN]        = scan_q;
      rd_mux[CTRL_SENA]        = sena_q;
    end else if (haddr[7:0] == MAN_OFS) begin
      rd_mux[MAN_CODE_LSB +: 4] = code_q;
    end else if (haddr[7:0] == IND_OFS) begin
      rd_mux = ind[31:0];
    end else if (haddr[7:0] == IND_HI_OFS) begin
      rd_mux[3:0] = ind[35:32];
    end else if (haddr[7:0] == KEY_OFS) begin
      rd_mux[3:0] = key_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q  <= 8'h0;
      wr_q    <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      wr_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        addr_q <= haddr[7:0];
        wr_q   <= hwrite;
        if (!hwrite) begin
          rdata_q <= rd_mux;
        end
      end
    end
  end

  assign wr_ctrl = wr_q && (addr_q == CTRL_OFS);
  assign wr_man  = wr_q && (addr_q == MAN_OFS);
  // a start during execution must not reset the running counters
  assign start_w = wr_ctrl && hwdata[CTRL_START] && (state_q != T_EXEC);
  assign clear_w = wr_ctrl && hwdata[CTRL_CLEAR];
  assign go_w    = wr_man && hwdata[MAN_GO];
  // go acts on the code written with it, not the previous one
  assign code_w  = wr_man ? hwdata[MAN_CODE_LSB +: 4] : code_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q   <= OP_RESET;
      supv_q <= 1'b0;
      scan_q <= 1'b0;
      sena_q <= 1'b0;
    end else if (wr_ctrl) begin
      op_q   <= hwdata[CTRL_OP_LSB +: 6];
      supv_q <= hwdata[CTRL_SUPV];
      scan_q <= hwdata[CTRL_SCAN];
      sena_q <= hwdata[CTRL_SENA];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q <= CODE_RESET;
    end else if (wr_man) begin
      code_q <= hwdata[MAN_CODE_LSB +: 4];
    end
  end

  // test sequence; a start while a test runs is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= T_IDLE;
    end else begin
      case (state_q)
        T_IDLE, T_DONE: begin
          if (start_w) begin
            state_q <= T_LOAD;
          end
        end
        T_LOAD: begin
          if (cpu.load_word && cpu.load_perr) begin
            state_q <= T_DONE;
          end else if (cpu.load_word && step_q[3]) begin
            state_q <= T_EXEC;
          end
        end
        T_EXEC: begin
          if (cpu.test_end && (bad_q || cpu.cmp_bad || toggle_q ||
                               rep_q == 5'h1)) begin
            state_q <= T_DONE;
          end
        end
        default: state_q <= T_IDLE;
      endcase
    end
  end

  // one load-step flag per loaded word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_q <= 4'h0;
    end else if (state_q != T_LOAD && start_w) begin
      step_q <= STEP_FIRST;
    end else if (state_q == T_LOAD && cpu.load_word) begin
      step_q <= {step_q[2:0], 1'b0};
    end
  end

  // sequence counter, load control and clock advance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= 3'h0;
      adv_q <= 1'b0;
    end else begin
      adv_q <= (state_q == T_EXEC);
      if (state_q != T_LOAD && start_w) begin
        seq_q <= SEQ_LOAD;
      end else if (state_q == T_LOAD && cpu.load_word && supv_q) begin
        seq_q <= seq_q - 3'h1;
      end else if (state_q == T_EXEC) begin
        seq_q <= seq_q + 3'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toggle_q <= 1'b0;
    end else if (state_q != T_LOAD && start_w) begin
      toggle_q <= 1'b0;
    end else if (state_q == T_EXEC && cpu.cmp_good) begin
      toggle_q <= ~toggle_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bad_q <= 1'b0;
    end else if (state_q == T_EXEC && cpu.test_end) begin
      bad_q <= 1'b0;
    end else if (state_q == T_EXEC && cpu.cmp_bad) begin
      bad_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rep_q <= REPEAT_INIT;
    end else if (state_q != T_LOAD && start_w) begin
      rep_q <= REPEAT_INIT;
    end else if (state_q == T_EXEC && cpu.test_end &&
                 !bad_q && !cpu.cmp_bad && !toggle_q) begin
      rep_q <= rep_q - 5'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (state_q == T_EXEC && cpu.test_end) begin
      if (bad_q || cpu.cmp_bad || toggle_q) begin
        fail_q <= 1'b1;
      end else if (rep_q == 5'h1) begin
        pass_q <= 1'b1;
      end
    end else if (clear_w || (state_q != T_LOAD && start_w)) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end
  end

  // parity flag; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perr_q <= 1'b0;
    end else if (state_q == T_LOAD && cpu.load_word && cpu.load_perr) begin
      perr_q <= 1'b1;
    end else if (clear_w || (state_q != T_LOAD && start_w)) begin
      perr_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= SRC_STORE;
    end else if (state_q == T_LOAD || state_q == T_EXEC) begin
      src_q <= SRC_COUNTER;
    end else if (scan_q && cpu.diagnose) begin
      src_q <= SRC_STORAGE;
    end else begin
      src_q <= SRC_STORE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_q   <= 1'b0;
      inhibit_q <= 1'b0;
    end else begin
      fetch_q   <= scan_q && cpu.diagnose;
      inhibit_q <= supv_q && !(sena_q && cpu.diagnose);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q <= 1'b0;
    end else if (cpu.hard_err) begin
      halt_q <= 1'b1;
    end else if (clear_w) begin
      halt_q <= 1'b0;
    end
  end

  // enable per clock doubles as running flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_q <= 4'h0;
    end else if (cpu.hard_err || halt_q) begin
      clk_q <= 4'h0;
    end else begin
      clk_q <= cpu.clk_req;
    end
  end

  // cleared once the interrupt is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
    end else if (cpu.err_reg_set && !cpu.psw13) begin
      pend_q <= 1'b1;
    end else if (cpu.mc_taken) begin
      pend_q <= 1'b0;
    end
  end

  // logout trigger, also from unmasked pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logout_q <= 1'b0;
    end else if (cpu.logout_err ||
                 (pend_q && cpu.psw13 && !logged_q && !logout_q)) begin
      logout_q <= 1'b1;
    end else if (cpu.logout_taken) begin
      logout_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logged_q <= 1'b0;
      mcreq_q  <= 1'b0;
    end else begin
      if (!pend_q || cpu.mc_taken) begin
        logged_q <= 1'b0;
      end else if (logout_q && cpu.logout_taken) begin
        logged_q <= 1'b1;
      end
      mcreq_q <= pend_q && logged_q && cpu.psw13 && !cpu.mc_taken;
    end
  end

  // interrupt possible when unmasked, clocks up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      allow_q <= 1'b0;
    end else begin
      allow_q <= cpu.psw13 && !halt_q && !cpu.hard_err;
    end
  end

  // held until start after leaving single
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      single_q     <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= pnl.start_pb;
      if (pnl.rate_single) begin
        single_q <= 1'b1;
      end else if (pnl.start_pb && !start_prev_q) begin
        single_q <= 1'b0;
      end
    end
  end

  // manual decode on general flags 4..7
  always_comb begin
    mop_d = '0;
    case (code_w)
      MC_HALT:      mop_d.halt_loop    = 1'b1;
      MC_STEP:      mop_d.instr_step   = !cpu.psw14;
      MC_SET_IAR:   mop_d.set_iar      = 1'b1;
      MC_REPEAT:    mop_d.repeat_instr = 1'b1;
      // main and bump storage via data reg
      MC_MS_DISP:   mop_d.stor_display = 1'b1;
      MC_MS_STORE:  mop_d.stor_store   = 1'b1;
      MC_BS_DISP: begin
        mop_d.stor_display = 1'b1;
        mop_d.bump         = 1'b1;
      end
      MC_BS_STORE: begin
        mop_d.stor_store = 1'b1;
        mop_d.bump       = 1'b1;
      end
      MC_KEY_DISP:  mop_d.key_display  = 1'b1;
      MC_LS_DISP:   mop_d.local_display = 1'b1;
      MC_LS_STORE:  mop_d.local_store   = 1'b1;
      default:      mop_d = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mop_q <= '0;
    end else begin
      mop_q <= go_w ? mop_d : '0;
    end
  end

  // compare only in stop/sync, not manual, not wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adrcmp_q <= 1'b0;
    end else begin
      adrcmp_q <= (code_q == MC_ADR_CMP) && pnl.stop_sync &&
                  !cpu.manual_state && !cpu.psw14;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_q <= 4'h0;
    end else if (go_w && code_w == MC_KEY_STORE) begin
      key_q <= pnl.data_sw[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdata_q <= 32'h0;
    end else if (go_w && (code_w == MC_MS_STORE ||
                          code_w == MC_LS_STORE ||
                          code_w == MC_BS_STORE)) begin
      mdata_q <= pnl.data_sw;
    end
  end

  always_comb begin
    ind              = '0;
    ind.pass         = pass_q;
    ind.fail         = fail_q;
    ind.toggle       = toggle_q;
    ind.rep_zero     = (rep_q == 5'h0);
    ind.op           = op_q;
    ind.seq          = seq_q;
    ind.load_step    = step_q;
    ind.parity_err   = perr_q;
    ind.supv         = supv_q;
    ind.scan         = scan_q;
    ind.store_enable = sena_q;
    ind.mode         = ctl_mode;
    ind.halt         = halt_q;
    ind.logout_tgr   = logout_q;
    ind.single_cycle = single_q;
    ind.clk_run      = {clk_q[3], clk_q[2], clk_q[1], clk_q[0]};
    ind.chk_allowed  = allow_q;
    ind.machine_check_pending     = pend_q;
  end

  // one-hot mode from a single source
  assign ctl_mode = {src_q == SRC_STORE, src_q == SRC_STORAGE,
                     src_q == SRC_COUNTER};

  assign clk_en          = clk_q;
  assign cycle_advance   = adv_q;
  assign storage_fetch   = fetch_q;
  assign storage_inhibit = inhibit_q;
  assign logout_req      = logout_q;
  assign mc_irpt_req     = mcreq_q;
  assign test_op         = op_q;
  assign manual_op       = mop_q;
  assign adr_compare     = adrcmp_q;
  assign manual_data     = mdata_q;
  assign key_reg         = key_q;

endmodule

`default_nettype wire

// [design/pin_sync.sv]
/*
  Three-stage synchroniser with agreement filter for panel pins.
  Assumes inputs asynchronous to hclk; output moves only when the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,    // bus clock
  input  wire logic         hresetn, // async reset, low
  input  wire logic [W-1:0] pin_in,  // raw pins
  output logic      [W-1:0] pin_out  // filtered level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // bits in disagreement hold the old level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= '0;
    end else begin
      out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end
  end

  assign pin_out = out_q;

endmodule

`default_nettype wire
